// File: dv/vcr_regs_asserts.sv
// checker: timing and reset relations of the oscillator control outputs
// assumes it is bound into vcr_regs and sees only that module's ports
`default_nettype none
module vcr_regs_asserts
	import vcr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic serSelN,
	input wire logic capCodeOverride,
	input wire logic freqCalEnable,
	input wire logic calRun,
	input wire logic calBypass,
	input wire logic [7:0] oscCapCode,
	input wire logic coreForceActive,
	input wire logic [2:0] forcedCore,
	input wire logic [2:0] calStartCore,
	input wire logic calSearchDown,
	input wire logic modulatorDither,
	input wire logic [1:0] tuningVoltageAdjust,
	input wire logic oscToOutbBufferPd,
	input wire logic oscToOutaBufferPd,
	input wire logic oscToDividerBufferPd
);
	logic [2:0] upCnt;
	logic up;
	logic rstHeld;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// edges since release; inner sync flops keep reset for two more edges
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) upCnt <= 3'h0;
		else if (upCnt != 3'h7) upCnt <= upCnt + 3'h1;
	end
	assign up = (upCnt == 3'h7);
	// reset seen at the previous edge too; the very first edge still shows power-up unknowns
	always_ff @(posedge sys_clk) begin
		rstHeld <= !reset_n;
	end
	// inputs reach the output flops at the next edge
	a_bypass_follows: assert property (up |-> calBypass == $past(capCodeOverride))
		else $error("bypass does not follow override");
	a_cal_gated: assert property (up |-> calRun ==
		($past(freqCalEnable) && !$past(capCodeOverride)))
		else $error("calibration run not gated by override");
	a_cal_exclusive: assert property (!(calRun && calBypass))
		else $error("calibration runs while bypassed");
	a_code_clamp: assert property (coreForceActive |-> oscCapCode <= CAP_CODE_MAX)
		else $error("forced capacitor code above range");
	a_force_needs_ovr: assert property (up && coreForceActive |-> $past(capCodeOverride))
		else $error("core forced without override");
	a_unforced_core: assert property (!coreForceActive |-> forcedCore == 3'h0)
		else $error("forced core shown while not forced");
	a_search_down: assert property (calSearchDown)
		else $error("search direction not downward");
	// only a finished frame may move register-held outputs
	a_fields_hold: assert property (serSelN [*6] ##0 up |-> $stable({modulatorDither,
		tuningVoltageAdjust, oscToOutbBufferPd, oscToOutaBufferPd, oscToDividerBufferPd,
		calStartCore}))
		else $error("field moved without a frame");
	a_reset_values: assert property (disable iff (1'b0) !reset_n && rstHeld |->
		oscToOutbBufferPd && !oscToOutaBufferPd && !oscToDividerBufferPd
		&& calStartCore == 3'h7)
		else $error("wrong output during reset");
	cover property (coreForceActive && oscCapCode == CAP_CODE_MAX);
	cover property (calStartCore != 3'h7);
	cover property (calRun);
	cover property ($fell(oscToOutbBufferPd));
endmodule

bind vcr_regs vcr_regs_asserts i_vcr_regs_asserts (.sys_clk, .reset_n, .serSelN,
	.capCodeOverride, .freqCalEnable, .calRun, .calBypass, .oscCapCode, .coreForceActive,
	.forcedCore, .calStartCore, .calSearchDown, .modulatorDither, .tuningVoltageAdjust,
	.oscToOutbBufferPd, .oscToOutaBufferPd, .oscToDividerBufferPd);
`default_nettype wire

// File: dv/vcr_regs_tb.sv
// testbench: serial frames and output checks for the oscillator control registers
// assumes vcr_regs with its checker bound; the bench drives every pin itself
`default_nettype none
module vcr_regs_tb
	import vcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, reset_n = 0, serClk = 0, serData = 0, serSelN = 1;
	logic capCodeOverride = 0, freqCalEnable = 0;
	logic serDataOut, calRun, calBypass, coreForceActive, calSearchDown, modulatorDither;
	logic oscToOutbBufferPd, oscToOutaBufferPd, oscToDividerBufferPd;
	logic [7:0] oscCapCode;
	logic [2:0] forcedCore, calStartCore;
	logic [1:0] tuningVoltageAdjust;
	logic [15:0] outA, outB, q, sCap, sCore, sDit, sBuf;
	int fail_count = 0, samples_checked = 0;
	logic [6:0] adr [8] = '{7'h16, 7'h17, 7'h18, 7'h19, 7'h1c, 7'h1d, 7'h1e, 7'h1f};
	logic [15:0] rstVal [8] = '{16'h0000, 16'h0800, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0400};
	logic [22:0] ops [15] = '{{7'h17, 16'h6c00}, {7'h16, 16'h00b7}, {7'h16, 16'h00b8},
		{7'h16, 16'h00ff}, {7'h16, 16'h0000}, {7'h17, 16'h2800}, {7'h17, 16'h4000},
		{7'h17, 16'h3c00}, {7'h1e, 16'h04c0}, {7'h1e, 16'h0040}, {7'h1e, 16'h0000},
		{7'h1f, 16'h0400}, {7'h1f, 16'h0200}, {7'h1f, 16'h0080}, {7'h1f, 16'h0000}};
	// outputs packed so one compare covers a whole group
	assign outA = {calRun, calBypass, coreForceActive, calSearchDown, modulatorDither,
		oscToOutbBufferPd, oscToOutaBufferPd, oscToDividerBufferPd, oscCapCode};
	assign outB = {8'h00, calStartCore, forcedCore, tuningVoltageAdjust};
	vcr_regs i_vcr_regs (.sys_clk, .reset_n, .serClk, .serData, .serSelN, .capCodeOverride,
		.freqCalEnable, .serDataOut, .calRun, .calBypass, .oscCapCode, .coreForceActive,
		.forcedCore, .calStartCore, .calSearchDown, .modulatorDither, .tuningVoltageAdjust,
		.oscToOutbBufferPd, .oscToOutaBufferPd, .oscToDividerBufferPd);
	initial forever #50 sys_clk = ~sys_clk;
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// n bits of a frame, msb first; readback taken just before each serClk fall
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d, input int n);
		logic [23:0] f;
		f = {rd, a, d};
		serSelN = 0;
		for (int i = 23; i > 23 - n; i--) begin
			serData = f[i];
			ticks(4);
			serClk = 1;
			ticks(4);
			if (i < 16) q[i] = serDataOut;
			serClk = 0;
		end
		serData = ~serData; // released line must not keep its last value
		ticks(4);
		serSelN = 1;
		ticks(6);
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		xfer(1'b0, a, d, 24);
		case (a)
			7'h16: sCap = d;
			7'h17: sCore = d;
			7'h1e: sDit = d;
			7'h1f: sBuf = d;
			default: ;
		endcase
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		xfer(1'b1, a, 16'h0000, 24);
		chk(q, exp);
	endtask
	task automatic shadow_rst();
		sCap = 16'h0000;
		sCore = 16'h0800;
		sDit = 16'h0000;
		sBuf = 16'h0400;
	endtask
	// expected outputs from the bench's own copy of the registers
	task automatic outs_ok();
		logic frc;
		logic [2:0] sel;
		logic [7:0] code;
		logic [15:0] eA, eB;
		frc = capCodeOverride & sCore[10];
		sel = sCore[13:11];
		code = (frc && sCap[7:0] > 8'hb7) ? 8'hb7 : sCap[7:0];
		eA = {freqCalEnable & ~capCodeOverride, capCodeOverride, frc, 1'b1, sDit[10],
			sBuf[10], sBuf[9], sBuf[7], code};
		eB = {8'h00, sCore[14] ? sel : 3'h7, frc ? sel : 3'h0, sDit[7:6]};
		chk(outA, eA);
		chk(outB, eB);
	endtask
	// hang guard, a little over twice the run length
	initial begin
		#3000000;
		fail_count++;
		test_done();
	end
	initial begin
		shadow_rst();
		ticks(20);
		outs_ok();
		reset_n = 1;
		ticks(4);
		for (int i = 0; i < 8; i++) rd(adr[i], rstVal[i]);
		// distinct word per place shows reserved bits kept and no aliasing
		for (int i = 0; i < 8; i++) wr(adr[i], {adr[i], ~adr[i], 2'h1});
		for (int i = 0; i < 8; i++) rd(adr[i], {adr[i], ~adr[i], 2'h1});
		wr(7'h20, 16'hffff);
		rd(7'h20, 16'h0000);
		xfer(1'b0, 7'h1f, 16'h0000, 23);
		rd(7'h1f, {7'h1f, ~7'h1f, 2'h1});
		outs_ok();
		// every override and calibration enable mix
		for (int k = 0; k < 4; k++) begin
			{capCodeOverride, freqCalEnable} = 2'(k);
			ticks(4);
			outs_ok();
		end
		// forced core, code limits, start core, dither, tuning and buffer powers
		for (int v = 1; v >= 0; v--) begin
			capCodeOverride = 1'(v);
			for (int j = 0; j < 15; j++) begin
				wr(ops[j][22:16], ops[j][15:0]);
				outs_ok();
			end
		end
		// second reset in mid-run brings back every default
		freqCalEnable = 0;
		reset_n = 0;
		shadow_rst();
		ticks(2);
		outs_ok();
		reset_n = 1;
		ticks(4);
		for (int i = 0; i < 8; i++) rd(adr[i], rstVal[i]);
		test_done();
	end
endmodule
`default_nettype wire

// File: logic/vcr_frame_if.sv
// interface: decoded serial frames passed from the shifter to the register bank
// assumes both ends run on the same system clock
`default_nettype none
interface vcr_frame_if;
	logic frameDone;
	logic frameRead;
	logic [6:0] frameAddr;
	logic [15:0] frameData;
	logic [15:0] readWord;

	modport shifter (output frameDone, output frameRead, output frameAddr, output frameData,
		input readWord);
	modport bank (input frameDone, input frameRead, input frameAddr, input frameData,
		output readWord);
endinterface
`default_nettype wire

// File: logic/vcr_pkg.sv
// package: register map, field layout and reset values of the oscillator control slice
// assumes a 10 MHz system clock and 16-bit registers on a 7-bit address
`default_nettype none
package vcr_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned REG_COUNT = 8;
	localparam int unsigned IDX_W = 3;
	localparam int unsigned FRAME_BITS = 24;
	localparam int unsigned ADDR_BITS_SEEN = 8;
	localparam logic [4:0] FRAME_BITS_C = 5'h18;
	localparam logic [4:0] ADDR_BITS_SEEN_C = 5'h08;
	localparam int unsigned FRAME_RW_BIT = 23;
	localparam int unsigned FRAME_ADDR_LSB = 16;

	// register offsets
	localparam logic [ADDR_W-1:0] OSC_CAPACITOR_CODE_ADDR = 7'h16;
	localparam logic [ADDR_W-1:0] OSC_CORE_SELECTION_ADDR = 7'h17;
	localparam logic [ADDR_W-1:0] RESERVED_DEFAULT_A_ADDR = 7'h18;
	localparam logic [ADDR_W-1:0] RESERVED_DEFAULT_B_ADDR = 7'h19;
	localparam logic [ADDR_W-1:0] RESERVED_DEFAULT_C_ADDR = 7'h1c;
	localparam logic [ADDR_W-1:0] RESERVED_DEFAULT_D_ADDR = 7'h1d;
	localparam logic [ADDR_W-1:0] DITHER_AND_TUNING_ADJUST_ADDR = 7'h1e;
	localparam logic [ADDR_W-1:0] OUTPUT_BUFFER_POWER_ADDR = 7'h1f;

	// storage index of each register
	localparam logic [IDX_W-1:0] IDX_CAP = 3'h0;
	localparam logic [IDX_W-1:0] IDX_CORE = 3'h1;
	localparam logic [IDX_W-1:0] IDX_RSV_A = 3'h2;
	localparam logic [IDX_W-1:0] IDX_RSV_B = 3'h3;
	localparam logic [IDX_W-1:0] IDX_RSV_C = 3'h4;
	localparam logic [IDX_W-1:0] IDX_RSV_D = 3'h5;
	localparam logic [IDX_W-1:0] IDX_DITHER = 3'h6;
	localparam logic [IDX_W-1:0] IDX_BUFPWR = 3'h7;

	// field positions
	localparam int unsigned CAP_CODE_LSB = 0;
	localparam int unsigned CAP_CODE_MSB = 7;
	localparam int unsigned CAL_START_CORE_EN_BIT = 14;
	localparam int unsigned CORE_SELECT_LSB = 11;
	localparam int unsigned CORE_SELECT_MSB = 13;
	localparam int unsigned CORE_FORCE_BIT = 10;
	localparam int unsigned MOD_DITHER_BIT = 10;
	localparam int unsigned TUNE_ADJ_LSB = 6;
	localparam int unsigned TUNE_ADJ_MSB = 7;
	localparam int unsigned OUTB_PD_BIT = 10;
	localparam int unsigned OUTA_PD_BIT = 9;
	localparam int unsigned DIV_PD_BIT = 7;

	// tuning limits and calibration defaults
	localparam logic [7:0] CAP_CODE_MAX = 8'hb7;
	localparam logic [2:0] CAL_DEFAULT_START_CORE = 3'h7;

	// reset values; reserved contents default to zero here
	localparam logic [DATA_W-1:0] OSC_CAPACITOR_CODE_RST = 16'h0000;
	localparam logic [DATA_W-1:0] OSC_CORE_SELECTION_RST = 16'h0800;
	localparam logic [DATA_W-1:0] RESERVED_DEFAULT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DITHER_AND_TUNING_ADJUST_RST = 16'h0000;
	localparam logic [DATA_W-1:0] OUTPUT_BUFFER_POWER_RST = 16'h0400;

	typedef logic [DATA_W-1:0] vcr_word_t;
endpackage
`default_nettype wire

// File: logic/vcr_regs.sv
// module: oscillator calibration and distribution control registers, top level
// assumes a serial master on serClk/serData/serSelN and analog blocks reading the controls
// Function
// - override set uses capacitor code, bypasses calibration
// - forced core tunes codes 0 to 183
// - start-core enable starts calibration at selected core
// - otherwise calibration starts at core 7, downward
// - 3-bit core select, default 1
// - force plus override uses selected core
// - dither bit switches modulator dither
// - output B buffer power-down, resets to 1
// - output A buffer power-down, resets to 0
// - divider buffer power-down, resets to 0
`default_nettype none
module vcr_regs
	import vcr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic serClk,
	input wire logic serData,
	input wire logic serSelN,
	input wire logic capCodeOverride,
	input wire logic freqCalEnable,
	output logic serDataOut,
	output logic calRun,
	output logic calBypass,
	output logic [7:0] oscCapCode,
	output logic coreForceActive,
	output logic [2:0] forcedCore,
	output logic [2:0] calStartCore,
	output logic calSearchDown,
	output logic modulatorDither,
	output logic [1:0] tuningVoltageAdjust,
	output logic oscToOutbBufferPd,
	output logic oscToOutaBufferPd,
	output logic oscToDividerBufferPd
);
	// reset release: async assert, two-flop release
	logic rstMeta_reg, rstSync_reg;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	vcr_frame_if frame ();
	logic serOutBit;

	vcr_serial_rx i_vcr_serial_rx (
		.sysClk(sys_clk),
		.rstN(rstSync_reg),
		.serClk(serClk),
		.serData(serData),
		.serSelN(serSelN),
		.frame(frame),
		.serOutBit(serOutBit)
	);

	// address decode, shared by the write path and the readback path
	function automatic logic [IDX_W:0] decodeAddr(input logic [ADDR_W-1:0] addr);
		logic [IDX_W:0] hitIdx;
		hitIdx = {1'b1, IDX_CAP};
		unique case (addr)
			OSC_CAPACITOR_CODE_ADDR: hitIdx = {1'b1, IDX_CAP};
			OSC_CORE_SELECTION_ADDR: hitIdx = {1'b1, IDX_CORE};
			RESERVED_DEFAULT_A_ADDR: hitIdx = {1'b1, IDX_RSV_A};
			RESERVED_DEFAULT_B_ADDR: hitIdx = {1'b1, IDX_RSV_B};
			RESERVED_DEFAULT_C_ADDR: hitIdx = {1'b1, IDX_RSV_C};
			RESERVED_DEFAULT_D_ADDR: hitIdx = {1'b1, IDX_RSV_D};
			DITHER_AND_TUNING_ADJUST_ADDR: hitIdx = {1'b1, IDX_DITHER};
			OUTPUT_BUFFER_POWER_ADDR: hitIdx = {1'b1, IDX_BUFPWR};
			default: hitIdx = {1'b0, IDX_CAP};
		endcase
		return hitIdx;
	endfunction

	function automatic vcr_word_t resetValue(input logic [IDX_W-1:0] idx);
		vcr_word_t value;
		value = RESERVED_DEFAULT_RST;
		unique case (idx)
			IDX_CAP: value = OSC_CAPACITOR_CODE_RST;
			IDX_CORE: value = OSC_CORE_SELECTION_RST;
			IDX_DITHER: value = DITHER_AND_TUNING_ADJUST_RST;
			IDX_BUFPWR: value = OUTPUT_BUFFER_POWER_RST;
			default: value = RESERVED_DEFAULT_RST;
		endcase
		return value;
	endfunction

	vcr_word_t regFile_reg [REG_COUNT];
	vcr_word_t regFile_next [REG_COUNT];
	logic [IDX_W:0] frameHit;

	assign frameHit = decodeAddr(frame.frameAddr);
	// unmapped reads return zero; reserved bits read back what was written
	assign frame.readWord = frameHit[IDX_W] ? regFile_reg[frameHit[IDX_W-1:0]] : 16'h0000;

	// whole-word writes; reserved contents kept as written
	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : g_word
			always_comb begin
				regFile_next[gi] = regFile_reg[gi];
				if (frame.frameDone && !frame.frameRead && frameHit[IDX_W]
						&& frameHit[IDX_W-1:0] == IDX_W'(gi)) begin
					regFile_next[gi] = frame.frameData;
				end
			end

			always_ff @(posedge sys_clk or negedge rstSync_reg) begin
				if (!rstSync_reg) begin
					regFile_reg[gi] <= resetValue(IDX_W'(gi));
				end else begin
					regFile_reg[gi] <= regFile_next[gi];
				end
			end
		end
	endgenerate

	// field views of the stored words
	logic [7:0] capField;
	logic [2:0] coreSelField;
	logic coreForceField, startEnField, forced;
	assign capField = regFile_reg[IDX_CAP][CAP_CODE_MSB:CAP_CODE_LSB];
	assign coreSelField = regFile_reg[IDX_CORE][CORE_SELECT_MSB:CORE_SELECT_LSB];
	assign coreForceField = regFile_reg[IDX_CORE][CORE_FORCE_BIT];
	assign startEnField = regFile_reg[IDX_CORE][CAL_START_CORE_EN_BIT];
	assign forced = capCodeOverride & coreForceField;

	// derived controls, registered so every output is a flop
	logic serDataOut_next, calRun_next, calBypass_next, coreForceActive_next;
	logic calSearchDown_next, modulatorDither_next;
	logic [7:0] oscCapCode_next;
	logic [2:0] forcedCore_next, calStartCore_next;
	logic [1:0] tuningVoltageAdjust_next;
	logic outbPd_next, outaPd_next, divPd_next;

	always_comb begin
		serDataOut_next = serOutBit;
		calBypass_next = capCodeOverride;
		calRun_next = freqCalEnable & ~capCodeOverride;
		oscCapCode_next = capField;
		// with a forced core, codes above the last in-core step would leave the core; hold at CAP_CODE_MAX
		if (forced && capField > CAP_CODE_MAX) begin
			oscCapCode_next = CAP_CODE_MAX;
		end
		coreForceActive_next = forced;
		forcedCore_next = forced ? coreSelField : 3'h0;
		calStartCore_next = startEnField ? coreSelField : CAL_DEFAULT_START_CORE;
		calSearchDown_next = 1'b1;
		modulatorDither_next = regFile_reg[IDX_DITHER][MOD_DITHER_BIT];
		// passed as written; the frequency choice is software's
		tuningVoltageAdjust_next = regFile_reg[IDX_DITHER][TUNE_ADJ_MSB:TUNE_ADJ_LSB];
		outbPd_next = regFile_reg[IDX_BUFPWR][OUTB_PD_BIT];
		outaPd_next = regFile_reg[IDX_BUFPWR][OUTA_PD_BIT];
		divPd_next = regFile_reg[IDX_BUFPWR][DIV_PD_BIT];
	end

	logic serDataOut_reg, calRun_reg, calBypass_reg, coreForceActive_reg;
	logic calSearchDown_reg, modulatorDither_reg;
	logic [7:0] oscCapCode_reg;
	logic [2:0] forcedCore_reg, calStartCore_reg;
	logic [1:0] tuningVoltageAdjust_reg;
	logic outbPd_reg, outaPd_reg, divPd_reg;

	// reset values mirror the register defaults so outputs are sane from the start
	always_ff @(posedge sys_clk or negedge rstSync_reg) begin
		if (!rstSync_reg) begin
			serDataOut_reg <= 1'b0;
			calRun_reg <= 1'b0;
			calBypass_reg <= 1'b0;
			oscCapCode_reg <= 8'h00;
			coreForceActive_reg <= 1'b0;
			forcedCore_reg <= 3'h0;
			calStartCore_reg <= CAL_DEFAULT_START_CORE;
			calSearchDown_reg <= 1'b1;
			modulatorDither_reg <= 1'b0;
			tuningVoltageAdjust_reg <= 2'h0;
			outbPd_reg <= OUTPUT_BUFFER_POWER_RST[OUTB_PD_BIT];
			outaPd_reg <= OUTPUT_BUFFER_POWER_RST[OUTA_PD_BIT];
			divPd_reg <= OUTPUT_BUFFER_POWER_RST[DIV_PD_BIT];
		end else begin
			serDataOut_reg <= serDataOut_next;
			calRun_reg <= calRun_next;
			calBypass_reg <= calBypass_next;
			oscCapCode_reg <= oscCapCode_next;
			coreForceActive_reg <= coreForceActive_next;
			forcedCore_reg <= forcedCore_next;
			calStartCore_reg <= calStartCore_next;
			calSearchDown_reg <= calSearchDown_next;
			modulatorDither_reg <= modulatorDither_next;
			tuningVoltageAdjust_reg <= tuningVoltageAdjust_next;
			outbPd_reg <= outbPd_next;
			outaPd_reg <= outaPd_next;
			divPd_reg <= divPd_next;
		end
	end

	assign serDataOut = serDataOut_reg;
	assign calRun = calRun_reg;
	assign calBypass = calBypass_reg;
	assign oscCapCode = oscCapCode_reg;
	assign coreForceActive = coreForceActive_reg;
	assign forcedCore = forcedCore_reg;
	assign calStartCore = calStartCore_reg;
	assign calSearchDown = calSearchDown_reg;
	assign modulatorDither = modulatorDither_reg;
	assign tuningVoltageAdjust = tuningVoltageAdjust_reg;
	assign oscToOutbBufferPd = outbPd_reg;
	assign oscToOutaBufferPd = outaPd_reg;
	assign oscToDividerBufferPd = divPd_reg;
endmodule
`default_nettype wire

// File: logic/vcr_serial_rx.sv
// module: serial programming port shifter, 24-bit frames, msb first
// assumes serial pins synchronous to sysClk and each serClk phase of 3+ clocks
`default_nettype none
module vcr_serial_rx
	import vcr_pkg::*;
(
	input wire logic sysClk,
	input wire logic rstN,
	input wire logic serClk,
	input wire logic serData,
	input wire logic serSelN,
	vcr_frame_if.shifter frame,
	output var logic serOutBit
);
	typedef enum logic [0:0] {
		VCR_IDLE = 1'b0,
		VCR_SHIFT = 1'b1
	} vcr_state_e;

	vcr_state_e state_reg, state_next;
	logic prevClk_reg, prevClk_next;
	logic [4:0] bitCount_reg, bitCount_next;
	logic [FRAME_BITS-1:0] shift_reg, shift_next;
	logic [DATA_W-1:0] outShift_reg, outShift_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic rw_reg, rw_next;
	logic loadPending_reg, loadPending_next;
	logic done_reg, done_next;
	logic outBit_reg, outBit_next;
	logic clkRise, clkFall;

	assign clkRise = serClk & ~prevClk_reg;
	assign clkFall = ~serClk & prevClk_reg;

	// frame sequencing: a frame counts only if 24 or more bits came before deselect; bits after the 24th are ignored
	always_comb begin
		state_next = state_reg;
		prevClk_next = serClk;
		bitCount_next = bitCount_reg;
		shift_next = shift_reg;
		outShift_next = outShift_reg;
		addr_next = addr_reg;
		rw_next = rw_reg;
		loadPending_next = 1'b0;
		done_next = 1'b0;
		outBit_next = outBit_reg;
		unique case (state_reg)
			VCR_IDLE: begin
				bitCount_next = 5'h00;
				outBit_next = 1'b0;
				if (!serSelN) begin
					state_next = VCR_SHIFT;
				end
			end
			VCR_SHIFT: begin
				if (serSelN) begin
					state_next = VCR_IDLE;
					done_next = (bitCount_reg == FRAME_BITS_C);
				end else if (clkRise && bitCount_reg != FRAME_BITS_C) begin
					shift_next = {shift_reg[FRAME_BITS-2:0], serData};
					bitCount_next = bitCount_reg + 5'h01;
					// address byte complete: fetch read word one clock later
					if (bitCount_reg + 5'h01 == ADDR_BITS_SEEN_C) begin
						rw_next = shift_reg[ADDR_BITS_SEEN-2];
						addr_next = {shift_reg[ADDR_W-2:0], serData};
						loadPending_next = 1'b1;
					end
				end else if (clkFall && bitCount_reg >= ADDR_BITS_SEEN_C) begin
					outBit_next = rw_reg & outShift_reg[DATA_W-1];
					outShift_next = {outShift_reg[DATA_W-2:0], 1'b0};
				end
				if (loadPending_reg) begin
					outShift_next = frame.readWord;
				end
			end
		endcase
	end

	always_ff @(posedge sysClk or negedge rstN) begin
		if (!rstN) begin
			state_reg <= VCR_IDLE;
			prevClk_reg <= 1'b0;
			bitCount_reg <= 5'h00;
			shift_reg <= 24'h000000;
			outShift_reg <= 16'h0000;
			addr_reg <= 7'h00;
			rw_reg <= 1'b0;
			loadPending_reg <= 1'b0;
			done_reg <= 1'b0;
			outBit_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			prevClk_reg <= prevClk_next;
			bitCount_reg <= bitCount_next;
			shift_reg <= shift_next;
			outShift_reg <= outShift_next;
			addr_reg <= addr_next;
			rw_reg <= rw_next;
			loadPending_reg <= loadPending_next;
			done_reg <= done_next;
			outBit_reg <= outBit_next;
		end
	end

	assign frame.frameDone = done_reg;
	assign frame.frameRead = rw_reg;
	assign frame.frameAddr = addr_reg;
	assign frame.frameData = shift_reg[DATA_W-1:0];
	assign serOutBit = outBit_reg;
endmodule
`default_nettype wire
